// [src/dual_pointer_and_fetch_timing.v]
// Summary of operation
// - with the compatibility fuse clear, fetch one internal instruction byte every clock, an external one every third clock.
// - fast mode instructions of 1 to 3 bytes take one clock per byte.
// - branches and calls take one extra clock; complex instructions take several.
// - fast mode instructions fetched externally take three times as long.
// - fuse set selects compatibility: fetch every third clock, six states, halved clock.
// - compatibility instructions take one, two or four twelve-clock machine cycles.
// - two 16-bit pointers, bytes at 82h/83h and 84h/85h.
// - pointer select bit chooses pointer zero when clear, pointer one when set.
// - all pointer bytes stay readable and writable whatever the select bit.
// - config bit 2 reads zero so incrementing the register toggles only select.
// - prefix A5h uses the opposite pointer, except the indirect jump.
// - a set direction bit turns pointer increment into decrement.
// - direction bits also set the direction of automatic updates.
// - auto-update bit set makes code and external moves post-step that pointer.
// - config register at A2h, resets to zero with bit 1 undefined.
`timescale 1ns/1ps
`include "dual_pointer_regs.vh"

module dual_pointer_and_fetch_timing (
    // clock and reset
    input wire clock,
    input wire reset,
    // configuration fuse pin
    input wire compat_fuse,
    // special-function access
    input wire [7:0] sfr_addr,
    input wire sfr_write,
    input wire sfr_read,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output reg sfr_hit,
    // opcode stream from the fetch stage
    input wire opcode_strobe,
    input wire [7:0] opcode,
    // pointer operation from the execute stage
    input wire [2:0] ptr_op,
    input wire [15:0] ptr_load_data,
    input wire [7:0] acc,
    output reg [15:0] ptr_addr,
    output reg ptr_addr_valid,
    output reg ptr_addr_is_one,
    // pointer and configuration state
    output reg [15:0] pointer_zero,
    output reg [15:0] pointer_one,
    output reg pointer_select,
    output reg signature_enable,
    output reg compat_mode,
    // instruction timing
    input wire instr_start,
    input wire [1:0] instr_bytes,
    input wire [1:0] instr_class,
    input wire [3:0] complex_cycles,
    input wire [2:0] machine_cycles,
    input wire external_fetch,
    output wire instr_busy,
    output wire fetch_strobe,
    output wire instr_done,
    output wire [2:0] machine_state
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [15:0] step16;
    input [15:0] value;
    input down;
    begin
        // plain 16-bit add keeps the wrap at both ends
        if (down) begin
            step16 = value - 16'h0001;
        end else begin
            step16 = value + 16'h0001;
        end
    end
endfunction

function [15:0] set_byte;
    input [15:0] value;
    input high;
    input [7:0] data;
    begin
        if (high) begin
            set_byte = {data, value[7:0]};
        end else begin
            set_byte = {value[15:8], data};
        end
    end
endfunction

// ----------------------------------------
// fuse synchroniser
// ----------------------------------------
reg fuse_meta;
reg fuse_sync;

always @(posedge clock or posedge reset) begin
    if (reset) begin
        fuse_meta <= 1'b1;
        fuse_sync <= 1'b1;
    end else begin
        fuse_meta <= compat_fuse;
        fuse_sync <= fuse_meta;
    end
end

// mode only changes between instructions so a timing run is never split
always @(posedge clock or posedge reset) begin
    if (reset) begin
        compat_mode <= 1'b1;
    end else if (!instr_busy && !instr_start) begin
        compat_mode <= fuse_sync;
    end
end

// timing sees the mode as it will be, so machine states clear with the mode
wire next_compat_mode;
assign next_compat_mode = (!instr_busy && !instr_start) ? fuse_sync : compat_mode;

// ----------------------------------------
// configuration register
// ----------------------------------------
reg ptr_zero_down;
reg ptr_one_down;
reg ptr_zero_auto_update;
reg ptr_one_auto_update;
wire [7:0] pointer_config_reg;

// bits 1 and 2 are never stored, so a +1 write cannot carry past select
assign pointer_config_reg = {ptr_one_auto_update, ptr_zero_auto_update, ptr_one_down, ptr_zero_down,
                             signature_enable, 1'b0, 1'b0, pointer_select};

wire config_write;
assign config_write = sfr_write && (sfr_addr == `ADDR_POINTER_CONFIG);

always @(posedge clock or posedge reset) begin
    if (reset) begin
        pointer_select <= |(`RESET_CONFIG & (8'h01 << `BIT_POINTER_SELECT));
        signature_enable <= 1'b0;
        ptr_zero_down <= 1'b0;
        ptr_one_down <= 1'b0;
        ptr_zero_auto_update <= 1'b0;
        ptr_one_auto_update <= 1'b0;
    end else if (config_write) begin
        pointer_select <= sfr_wdata[`BIT_POINTER_SELECT];
        signature_enable <= sfr_wdata[`BIT_SIGNATURE_ENABLE];
        ptr_zero_down <= sfr_wdata[`BIT_PTR_ZERO_DOWN];
        ptr_one_down <= sfr_wdata[`BIT_PTR_ONE_DOWN];
        ptr_zero_auto_update <= sfr_wdata[`BIT_PTR_ZERO_AUTO_UPDATE];
        ptr_one_auto_update <= sfr_wdata[`BIT_PTR_ONE_AUTO_UPDATE];
    end
end

// ----------------------------------------
// prefix tracking
// ----------------------------------------
reg prefix_pending;
reg prefix_armed;

// the prefix only arms the instruction whose opcode follows it
always @(posedge clock or posedge reset) begin
    if (reset) begin
        prefix_pending <= 1'b0;
        prefix_armed <= 1'b0;
    end else if (opcode_strobe) begin
        if (opcode == `PREFIX_OPCODE) begin
            prefix_pending <= 1'b1;
            prefix_armed <= 1'b0;
        end else begin
            prefix_armed <= prefix_pending;
            prefix_pending <= 1'b0;
        end
    end
end

// ----------------------------------------
// pointer operation decode
// ----------------------------------------
reg use_one;
reg target_down;
reg target_auto;
reg [15:0] target_value;
reg [15:0] next_target;
reg write_target;

always @*  begin
    // jump through accumulator ignores the prefix
    if (ptr_op == `OP_JMP) begin
        use_one = pointer_select;
    end else begin
        use_one = pointer_select ^ prefix_armed;
    end
    target_value = use_one ? pointer_one : pointer_zero;
    target_down = use_one ? ptr_one_down : ptr_zero_down;
    target_auto = use_one ? ptr_one_auto_update : ptr_zero_auto_update;
    next_target = target_value;
    write_target = 1'b0;
    case (ptr_op)
        `OP_LOAD: begin
            next_target = ptr_load_data;
            write_target = 1'b1;
        end
        `OP_INC: begin
            next_target = step16(target_value, target_down);
            write_target = 1'b1;
        end
        `OP_MOVX, `OP_MOVC: begin
            if (target_auto) begin
                next_target = step16(target_value, target_down);
                write_target = 1'b1;
            end
        end
        default: begin
            next_target = target_value;
            write_target = 1'b0;
        end
    endcase
end

// ----------------------------------------
// pointer registers
// ----------------------------------------
wire [1:0] byte_sel;
wire hit_zero;
wire hit_one;
assign hit_zero = (sfr_addr == `ADDR_POINTER_ZERO_LOW) || (sfr_addr == `ADDR_POINTER_ZERO_HIGH);
assign hit_one = (sfr_addr == `ADDR_POINTER_ONE_LOW) || (sfr_addr == `ADDR_POINTER_ONE_HIGH);
assign byte_sel = {sfr_addr == `ADDR_POINTER_ONE_HIGH, sfr_addr == `ADDR_POINTER_ZERO_HIGH};

// a byte written by software in the same cycle as an operation wins for that byte
always @(posedge clock or posedge reset) begin
    if (reset) begin
        pointer_zero <= `RESET_POINTER;
        pointer_one <= `RESET_POINTER;
    end else begin
        if (sfr_write && hit_zero) begin
            pointer_zero <= set_byte(write_target && !use_one ? next_target : pointer_zero,
                                     byte_sel[0], sfr_wdata);
        end else if (write_target && !use_one) begin
            pointer_zero <= next_target;
        end
        if (sfr_write && hit_one) begin
            pointer_one <= set_byte(write_target && use_one ? next_target : pointer_one,
                                    byte_sel[1], sfr_wdata);
        end else if (write_target && use_one) begin
            pointer_one <= next_target;
        end
    end
end

// ----------------------------------------
// access address (value before any post-step)
// ----------------------------------------
always @(posedge clock or posedge reset) begin
    if (reset) begin
        ptr_addr <= 16'h0000;
        ptr_addr_valid <= 1'b0;
        ptr_addr_is_one <= 1'b0;
    end else begin
        ptr_addr_valid <= (ptr_op == `OP_MOVX) || (ptr_op == `OP_MOVC) || (ptr_op == `OP_JMP);
        ptr_addr_is_one <= use_one;
        if (ptr_op == `OP_MOVC || ptr_op == `OP_JMP) begin
            ptr_addr <= target_value + {8'h00, acc};
        end else begin
            ptr_addr <= target_value;
        end
    end
end

// ----------------------------------------
// special-function read port
// ----------------------------------------
always @(posedge clock or posedge reset) begin
    if (reset) begin
        sfr_rdata <= 8'h00;
        sfr_hit <= 1'b0;
    end else begin
        sfr_hit <= sfr_read && (hit_zero || hit_one || sfr_addr == `ADDR_POINTER_CONFIG);
        if (!sfr_read) begin
            sfr_rdata <= 8'h00;
        end else begin
            case (sfr_addr)
                `ADDR_POINTER_ZERO_LOW: begin
                    sfr_rdata <= pointer_zero[7:0];
                end
                `ADDR_POINTER_ZERO_HIGH: begin
                    sfr_rdata <= pointer_zero[15:8];
                end
                `ADDR_POINTER_ONE_LOW: begin
                    sfr_rdata <= pointer_one[7:0];
                end
                `ADDR_POINTER_ONE_HIGH: begin
                    sfr_rdata <= pointer_one[15:8];
                end
                `ADDR_POINTER_CONFIG: begin
                    sfr_rdata <= pointer_config_reg & `MASK_CONFIG_STORED;
                end
                default: begin
                    sfr_rdata <= 8'h00;
                end
            endcase
        end
    end
end

// ----------------------------------------
// fetch and execute timing
// ----------------------------------------
fetch_timing u_fetch_timing (
    .clock(clock),
    .reset(reset),
    .compat_mode(next_compat_mode),
    .start(instr_start),
    .instr_bytes(instr_bytes),
    .instr_class(instr_class),
    .complex_cycles(complex_cycles),
    .machine_cycles(machine_cycles),
    .external_fetch(external_fetch),
    .busy(instr_busy),
    .fetch_strobe(fetch_strobe),
    .instr_done(instr_done),
    .state_num(machine_state)
);

endmodule // dual_pointer_and_fetch_timing

// [src/dual_pointer_regs.vh]
`ifndef DUAL_POINTER_REGS_VH
`define DUAL_POINTER_REGS_VH

// ----------------------------------------
// special-function addresses
// ----------------------------------------
`define ADDR_POINTER_ZERO_LOW 8'h82
`define ADDR_POINTER_ZERO_HIGH 8'h83
`define ADDR_POINTER_ONE_LOW 8'h84
`define ADDR_POINTER_ONE_HIGH 8'h85
`define ADDR_POINTER_CONFIG 8'hA2

// ----------------------------------------
// pointer_config_reg fields
// ----------------------------------------
`define BIT_POINTER_SELECT 0
`define BIT_RESERVED_ONE 1
`define BIT_HARD_ZERO 2
`define BIT_SIGNATURE_ENABLE 3
`define BIT_PTR_ZERO_DOWN 4
`define BIT_PTR_ONE_DOWN 5
`define BIT_PTR_ZERO_AUTO_UPDATE 6
`define BIT_PTR_ONE_AUTO_UPDATE 7
`define MASK_CONFIG_STORED 8'hF9

// ----------------------------------------
// reset values
// ----------------------------------------
`define RESET_POINTER 16'h0000
`define RESET_CONFIG 8'h00

// ----------------------------------------
// prefix and pointer operations
// ----------------------------------------
`define PREFIX_OPCODE 8'hA5
`define OP_NONE 3'h0
`define OP_LOAD 3'h1
`define OP_INC 3'h2
`define OP_MOVX 3'h3
`define OP_MOVC 3'h4
`define OP_JMP 3'h5

// ----------------------------------------
// fetch timing
// ----------------------------------------
`define CLASS_NORMAL 2'h0
`define CLASS_BRANCH 2'h1
`define CLASS_COMPLEX 2'h2
`define FAST_BRANCH_EXTRA 8'h01
`define EXTERNAL_FETCH_FACTOR 8'h03
`define COMPAT_FETCH_DIVIDE 2'h3
`define COMPAT_STATES 3'h6
`define COMPAT_CLOCKS_PER_MC 8'h0C

`endif

// [src/fetch_timing.v]
`timescale 1ns/1ps
`include "dual_pointer_regs.vh"

module fetch_timing (
    // clock and reset
    input wire clock,
    input wire reset,
    // mode
    input wire compat_mode,
    // instruction request
    input wire start,
    input wire [1:0] instr_bytes,
    input wire [1:0] instr_class,
    input wire [3:0] complex_cycles,
    input wire [2:0] machine_cycles,
    input wire external_fetch,
    // timing outputs
    output reg busy,
    output reg fetch_strobe,
    output reg instr_done,
    output reg [2:0] state_num
);

reg [7:0] clocks_left;
reg [1:0] bytes_left;
reg [1:0] fetch_phase;
reg slow_fetch;
reg half_phase;
reg [7:0] base;
reg [7:0] total;
reg fetch_now;

// ----------------------------------------
// length of the instruction in clocks
// ----------------------------------------
always @* begin
    if (instr_class == `CLASS_BRANCH) begin
        base = {6'h00, instr_bytes} + `FAST_BRANCH_EXTRA;
    end else if (instr_class == `CLASS_COMPLEX) begin
        base = {4'h0, complex_cycles};
    end else begin
        base = {6'h00, instr_bytes};
    end
    if (compat_mode) begin
        total = {5'h00, machine_cycles} * `COMPAT_CLOCKS_PER_MC;
    end else if (external_fetch) begin
        total = base * `EXTERNAL_FETCH_FACTOR;
    end else begin
        total = base;
    end
    // fast internal fetches every clock, otherwise every third
    fetch_now = busy && (bytes_left != 2'h0) && (!slow_fetch || fetch_phase == 2'h0);
end

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge clock or posedge reset) begin
    if (reset) begin
        busy <= 1'b0;
        fetch_strobe <= 1'b0;
        instr_done <= 1'b0;
        clocks_left <= 8'h00;
        bytes_left <= 2'h0;
        fetch_phase <= 2'h0;
        slow_fetch <= 1'b0;
    end else begin
        fetch_strobe <= fetch_now;
        instr_done <= 1'b0;
        if (!busy) begin
            if (start && total != 8'h00) begin
                busy <= 1'b1;
                clocks_left <= total;
                bytes_left <= instr_bytes;
                fetch_phase <= 2'h0;
                slow_fetch <= compat_mode || external_fetch;
            end
        end else begin
            if (fetch_now) begin
                bytes_left <= bytes_left - 2'h1;
            end
            fetch_phase <= (fetch_phase == `COMPAT_FETCH_DIVIDE - 2'h1) ? 2'h0 : fetch_phase + 2'h1;
            clocks_left <= clocks_left - 8'h01;
            if (clocks_left == 8'h01) begin
                busy <= 1'b0;
                instr_done <= 1'b1;
            end
        end
    end
end

// ----------------------------------------
// machine-cycle states on the halved clock
// ----------------------------------------
always @(posedge clock or posedge reset) begin
    if (reset) begin
        half_phase <= 1'b0;
        state_num <= 3'h0;
    end else if (!compat_mode) begin
        half_phase <= 1'b0;
        state_num <= 3'h0;
    end else begin
        half_phase <= ~half_phase;
        if (half_phase) begin
            state_num <= (state_num == `COMPAT_STATES - 3'h1) ? 3'h0 : state_num + 3'h1;
        end
    end
end

endmodule // fetch_timing

// [verification/dual_pointer_and_fetch_timing_tb_top.sv]
`timescale 1ns/1ps
`include "dual_pointer_regs.vh"

module dual_pointer_and_fetch_timing_tb_top;
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg compat_fuse = 1'b1;
    reg sfr_write = 1'b0, sfr_read = 1'b0, opcode_strobe = 1'b0, instr_start = 1'b0, external_fetch = 1'b0;
    reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, opcode = 8'h00, acc = 8'h00;
    reg [2:0] ptr_op = 3'h0, machine_cycles = 3'h0;
    reg [15:0] ptr_load_data = 16'h0000;
    reg [1:0] instr_bytes = 2'h0, instr_class = 2'h0;
    reg [3:0] complex_cycles = 4'h0;
    wire [7:0] sfr_rdata;
    wire [15:0] ptr_addr, pointer_zero, pointer_one;
    wire [2:0] machine_state;
    wire sfr_hit, ptr_addr_valid, ptr_addr_is_one, pointer_select, signature_enable, compat_mode;
    wire instr_busy, fetch_strobe, instr_done;
    // expected pointer and config state
    reg [15:0] m0 = 16'h0000, m1 = 16'h0000;
    reg [7:0] mcfg = 8'h00;
    integer errors = 0, tests_run = 0, cycles = 0, i;

    always #20 clock = ~clock;

    dual_pointer_and_fetch_timing u_dual_pointer_and_fetch_timing (
        .clock(clock), .reset(reset), .compat_fuse(compat_fuse), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
        .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .opcode_strobe(opcode_strobe), .opcode(opcode), .ptr_op(ptr_op), .ptr_load_data(ptr_load_data),
        .acc(acc), .ptr_addr(ptr_addr), .ptr_addr_valid(ptr_addr_valid), .ptr_addr_is_one(ptr_addr_is_one),
        .pointer_zero(pointer_zero), .pointer_one(pointer_one), .pointer_select(pointer_select),
        .signature_enable(signature_enable), .compat_mode(compat_mode), .instr_start(instr_start),
        .instr_bytes(instr_bytes), .instr_class(instr_class), .complex_cycles(complex_cycles),
        .machine_cycles(machine_cycles), .external_fetch(external_fetch), .instr_busy(instr_busy),
        .fetch_strobe(fetch_strobe), .instr_done(instr_done), .machine_state(machine_state)
    );

    // --------------------------------
    // shared tasks
    // --------------------------------
    task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task sfr_wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock);
            sfr_addr = a;
            sfr_wdata = d;
            sfr_write = 1'b1;
            @(negedge clock);
            sfr_write = 1'b0;
            case (a)
                `ADDR_POINTER_ZERO_LOW: m0[7:0] = d;
                `ADDR_POINTER_ZERO_HIGH: m0[15:8] = d;
                `ADDR_POINTER_ONE_LOW: m1[7:0] = d;
                `ADDR_POINTER_ONE_HIGH: m1[15:8] = d;
                `ADDR_POINTER_CONFIG: mcfg = d & 8'hF9;
            endcase
        end
    endtask

    task sfr_rd(input [7:0] a);
        reg [8:0] e;
        begin
            case (a)
                `ADDR_POINTER_ZERO_LOW: e = {1'b1, m0[7:0]};
                `ADDR_POINTER_ZERO_HIGH: e = {1'b1, m0[15:8]};
                `ADDR_POINTER_ONE_LOW: e = {1'b1, m1[7:0]};
                `ADDR_POINTER_ONE_HIGH: e = {1'b1, m1[15:8]};
                `ADDR_POINTER_CONFIG: e = {1'b1, mcfg};
                default: e = 9'h000;
            endcase
            @(negedge clock);
            sfr_addr = a;
            sfr_read = 1'b1;
            @(negedge clock);
            sfr_read = 1'b0;
            check({7'h00, sfr_hit, sfr_rdata}, {7'h00, e}, "sfr read");
        end
    endtask

    // pointer operation, optionally behind the prefix opcode
    task ptr_do(input pre, input [2:0] op, input [7:0] a);
        reg sel;
        reg [15:0] base, nv;
        begin
            sel = mcfg[0] ^ (pre && op != `OP_JMP);
            base = sel ? m1 : m0;
            nv = base;
            if (op == `OP_LOAD) nv = {a, 8'h5A};
            if (op == `OP_INC || ((op == `OP_MOVX || op == `OP_MOVC) && mcfg[6 + sel]))
                nv = mcfg[4 + sel] ? base - 16'h0001 : base + 16'h0001;
            if (pre) begin
                @(negedge clock);
                opcode_strobe = 1'b1;
                opcode = `PREFIX_OPCODE;
            end
            @(negedge clock);
            opcode_strobe = 1'b1;
            opcode = 8'h00;
            @(negedge clock);
            opcode_strobe = 1'b0;
            ptr_op = op;
            acc = a;
            ptr_load_data = {a, 8'h5A};
            @(negedge clock);
            ptr_op = `OP_NONE;
            if (sel) m1 = nv;
            else m0 = nv;
            check(pointer_zero, m0, "ptr zero");
            check(pointer_one, m1, "ptr one");
            check({15'h0000, pointer_select}, {15'h0000, mcfg[0]}, "select");
            check({15'h0000, signature_enable}, {15'h0000, mcfg[3]}, "sig");
            if (op >= `OP_MOVX) begin
                check(ptr_addr, base + ((op == `OP_MOVX) ? 16'h0000 : {8'h00, a}), "address");
                check({14'h0000, ptr_addr_valid, ptr_addr_is_one}, {14'h0000, 1'b1, sel}, "used");
            end
        end
    endtask

    task run_instr(input [1:0] b, input [1:0] cls, input [3:0] cx, input [2:0] mc, input ext, input [7:0] n_exp);
        integer n, fs;
        begin
            @(negedge clock);
            instr_start = 1'b1;
            instr_bytes = b;
            instr_class = cls;
            complex_cycles = cx;
            machine_cycles = mc;
            external_fetch = ext;
            @(negedge clock);
            instr_start = 1'b0;
            n = 1;
            fs = 0;
            while (instr_done !== 1'b1 && n < 100) begin
                fs = fs + (fetch_strobe === 1'b1);
                @(negedge clock);
                n = n + 1;
            end
            fs = fs + (fetch_strobe === 1'b1);
            check(n[15:0], {8'h00, n_exp} + 16'h0001, "cycles");
            check(fs[15:0], {14'h0000, b}, "fetches");
        end
    endtask

    // --------------------------------
    // test sequence
    // --------------------------------
    initial begin
        repeat (8) @(negedge clock);
        reset = 1'b0;
        check({15'h0000, compat_mode}, 16'h0001, "compat");
        for (i = 0; i < 7; i = i + 1) sfr_rd(8'h82 + i[7:0]);
        sfr_rd(`ADDR_POINTER_CONFIG);
        for (i = 0; i < 8; i = i + 1) sfr_wr(8'h82 + {6'h00, i[1:0]}, 8'hC3 ^ i[7:0]);
        sfr_wr(`ADDR_POINTER_CONFIG, 8'h01);
        for (i = 0; i < 6; i = i + 1) sfr_rd(8'h82 + i[7:0]);
        sfr_wr(`ADDR_POINTER_CONFIG, 8'hFF);
        sfr_rd(`ADDR_POINTER_CONFIG);
        sfr_wr(`ADDR_POINTER_CONFIG, 8'hF1 + 8'h01);
        sfr_rd(`ADDR_POINTER_CONFIG);
        $display("test registers done");
        sfr_wr(`ADDR_POINTER_ZERO_LOW, 8'hFF);
        sfr_wr(`ADDR_POINTER_ZERO_HIGH, 8'hFF);
        sfr_wr(`ADDR_POINTER_ONE_LOW, 8'h00);
        sfr_wr(`ADDR_POINTER_ONE_HIGH, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            sfr_wr(`ADDR_POINTER_CONFIG, {2'b00, i[0], i[1], 3'b000, i[2]});
            ptr_do(i[0] ^ i[3], `OP_INC, 8'h00);
        end
        $display("test increment done");
        for (i = 0; i < 32; i = i + 1) begin
            sfr_wr(`ADDR_POINTER_CONFIG, {i[1:0], i[3:2], 3'b000, i[4]});
            ptr_do(i[0], `OP_MOVX, 8'h00);
            ptr_do(i[1], `OP_MOVC, 8'hF0 ^ i[7:0]);
            ptr_do(i[2], `OP_JMP, 8'h81);
            ptr_do(i[3], `OP_LOAD, i[7:0]);
        end
        $display("test auto update done");
        run_instr(2'h1, 2'h0, 4'h0, 3'h1, 1'b0, 8'h0C);
        run_instr(2'h1, 2'h0, 4'h0, 3'h2, 1'b0, 8'h18);
        run_instr(2'h1, 2'h0, 4'h0, 3'h4, 1'b0, 8'h30);
        compat_fuse = 1'b0;
        repeat (4) @(negedge clock);
        check({15'h0000, compat_mode}, 16'h0000, "compat");
        for (i = 1; i < 4; i = i + 1) run_instr(i[1:0], 2'h0, 4'h0, 3'h1, 1'b0, i[7:0]);
        run_instr(2'h2, 2'h1, 4'h0, 3'h1, 1'b0, 8'h03);
        run_instr(2'h1, 2'h2, 4'h5, 3'h1, 1'b0, 8'h05);
        run_instr(2'h2, 2'h0, 4'h0, 3'h1, 1'b1, 8'h06);
        $display("test timing done");
        print_verdict;
    end

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("timeout reached");
            print_verdict;
        end
    end
endmodule // dual_pointer_and_fetch_timing_tb_top

// [verification/dual_pointer_checker_sva.sv]
`timescale 1ns/1ps

module dual_pointer_checker (
    // clock and reset
    input wire clock,
    input wire reset,
    // register access
    input wire [7:0] sfr_addr,
    input wire sfr_write,
    input wire sfr_read,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    // pointers
    input wire [2:0] ptr_op,
    input wire [7:0] acc,
    input wire [15:0] ptr_addr,
    input wire ptr_addr_valid,
    input wire ptr_addr_is_one,
    input wire [15:0] pointer_zero,
    input wire [15:0] pointer_one,
    input wire pointer_select,
    // timing
    input wire compat_mode,
    input wire instr_start,
    input wire [1:0] instr_bytes,
    input wire [1:0] instr_class,
    input wire [2:0] machine_cycles,
    input wire external_fetch,
    input wire instr_busy,
    input wire instr_done,
    input wire [2:0] machine_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire mapped = (sfr_addr >= 8'h82 && sfr_addr <= 8'h85) || sfr_addr == 8'hA2;
    wire go = instr_start && !instr_busy;
    wire fast = !compat_mode && go && !external_fetch;

    a_read_hit: assert property (sfr_read && mapped |=> sfr_hit)
        else $error("mapped read gave no hit");
    a_unmapped_quiet: assert property (sfr_read && !mapped |=> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("unmapped read answered");
    a_config_zero_bits: assert property (sfr_read && sfr_addr == 8'hA2 |=> sfr_rdata[2:1] == 2'b00)
        else $error("config bits 2:1 not zero");
    a_select_tracks: assert property (sfr_write && sfr_addr == 8'hA2 |=> pointer_select == $past(sfr_wdata[0]))
        else $error("select bit not written");
    a_jmp_selected: assert property (ptr_op == 3'h5 |=> ptr_addr_is_one == $past(pointer_select) &&
        ptr_addr == $past(pointer_select ? pointer_one : pointer_zero) + $past(acc))
        else $error("jump used wrong pointer");
    a_inc_one_step: assert property (ptr_op == 3'h2 && !sfr_write |=>
        ($stable(pointer_zero) != $stable(pointer_one)) &&
        (pointer_zero - $past(pointer_zero) + pointer_one - $past(pointer_one)) inside {16'h0001, 16'hFFFF})
        else $error("increment not a single step");
    a_access_valid: assert property (ptr_op inside {3'h3, 3'h4, 3'h5} |=> ptr_addr_valid)
        else $error("access address not flagged");
    a_state_range: assert property (machine_state <= 3'h5 && (compat_mode || machine_state == 3'h0))
        else $error("machine state out of range");
    a_fast_one_byte: assert property (fast && instr_class == 2'h0 && instr_bytes == 2'h1
        |=> !instr_done ##1 instr_done)
        else $error("one byte instruction not one clock");
    a_fast_three_clk: assert property (!compat_mode && go && ((instr_class == 2'h1 && instr_bytes == 2'h2 &&
        !external_fetch) || (instr_class == 2'h0 && instr_bytes == 2'h1 && external_fetch))
        |=> (!instr_done) [*3] ##1 instr_done)
        else $error("branch or external timing wrong");
    a_compat_one_mc: assert property (compat_mode && go && machine_cycles == 3'h1
        |=> (!instr_done) [*8] ##1 (!instr_done) [*4] ##1 instr_done)
        else $error("machine cycle not twelve clocks");

    cover property (compat_mode && go);
    cover property (fast && instr_class == 2'h2);
    cover property (ptr_op == 3'h5);
    cover property (sfr_read && sfr_addr == 8'hA2);
endmodule // dual_pointer_checker

bind dual_pointer_and_fetch_timing dual_pointer_checker u_dual_pointer_checker (
    .clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ptr_op(ptr_op), .acc(acc),
    .ptr_addr(ptr_addr), .ptr_addr_valid(ptr_addr_valid), .ptr_addr_is_one(ptr_addr_is_one),
    .pointer_zero(pointer_zero), .pointer_one(pointer_one), .pointer_select(pointer_select),
    .compat_mode(compat_mode), .instr_start(instr_start), .instr_bytes(instr_bytes), .instr_class(instr_class),
    .machine_cycles(machine_cycles), .external_fetch(external_fetch), .instr_busy(instr_busy),
    .instr_done(instr_done), .machine_state(machine_state)
);
